// ### chan_cfg.svh
// Offsets, codes and reset values of the capture/compare channel
`ifndef CHAN_CFG_SVH
`define CHAN_CFG_SVH
`define OFS_CTRL      8'h00
`define OFS_VALUE     8'h04
`define OFS_STATUS    8'h08
`define OFS_CLEAR     8'h0C
`define OFS_ENABLE    8'h10
`define CTRL_RESET    16'h0000
`define VALUE_RESET   16'h0000
`define RESP_OKAY     2'b00
`define RESP_SLVERR   2'b10
`define EDGE_NONE     2'b00
`define EDGE_RISE     2'b01
`define EDGE_FALL     2'b10
`define EDGE_BOTH     2'b11
`define SRC_A         2'b00
`define SRC_B         2'b01
`define SRC_GND       2'b10
`define SRC_VCC       2'b11
`define MODE_DIRECT   3'h0
`define MODE_SET      3'h1
`define MODE_TOG_RST  3'h2
`define MODE_SET_RST  3'h3
`define MODE_TOGGLE   3'h4
`define MODE_RESET    3'h5
`define MODE_TOG_SET  3'h6
`define MODE_RST_SET  3'h7
`endif

// ### chan_pkg.sv
// Types shared by the capture/compare channel modules
`default_nettype none
package chan_pkg;
    // Channel control word, bit 15 first
    typedef struct packed {
        logic [1:0] edgeSelect;
        logic [1:0] inputSourceSelect;
        logic       syncCapture;
        logic       latchedSyncInput;
        logic       unusedBit;
        logic       latchOnEdgeSelect;
        logic [2:0] pinActionSelect;
        logic       channelIrqEnable;
        logic       selectedInputLevel;
        logic       outBit;
        logic       captureOverflow;
        logic       channelIrqFlag;
    } ctrl_t;
    // Sticky event bits of the status register
    typedef struct packed {
        logic overflow;
        logic compare;
        logic capture;
    } event_t;
    typedef enum logic [1:0] {WR_IDLE = 2'b01, WR_RESP = 2'b10} wr_state_t;
    typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_RESP = 2'b10} rd_state_t;
endpackage
`default_nettype wire

// ### pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`default_nettype none
module pin_sync (
    input  wire logic clock,   // Timer clock
    input  wire logic arst_n,  // Async reset, active low
    input  wire logic ce,      // Clock enable
    input  wire logic pin,     // Asynchronous pin
    output var  logic level    // Filtered level
);
    logic stage1;
    logic stage2;
    logic stage3;

    // Stage one feeds only stage two, so metastability stays contained
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
            level  <= 1'b0;
        end else if (ce) begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                level <= stage3;
            end
        end
    end
endmodule
`default_nettype wire

// ### pin_action_unit.sv
// Output unit: drives the channel pin from the two match events
`include "chan_cfg.svh"
`default_nettype none
module pin_action_unit
    import chan_pkg::*;
(
    input  wire logic       clock,     // Timer clock
    input  wire logic       arst_n,    // Async reset, active low
    input  wire logic       ce,        // Clock enable
    input  wire logic [2:0] mode,      // Pin action select
    input  wire logic       outBit,    // Direct output bit
    input  wire logic       chanHit,   // Channel match pulse
    input  wire logic       periodHit, // Period match pulse
    output var  logic       pinLevel   // Channel output
);
    // Channel match acts first, period match decides when both coincide
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pinLevel <= 1'b0;
        end else if (ce) begin
            case (mode)
                `MODE_DIRECT: pinLevel <= outBit;
                `MODE_SET: if (chanHit) pinLevel <= 1'b1;
                `MODE_TOG_RST: begin
                    if (periodHit) pinLevel <= 1'b0;
                    else if (chanHit) pinLevel <= !pinLevel;
                end
                `MODE_SET_RST: begin
                    if (periodHit) pinLevel <= 1'b0;
                    else if (chanHit) pinLevel <= 1'b1;
                end
                `MODE_TOGGLE: if (chanHit) pinLevel <= !pinLevel;
                `MODE_RESET: if (chanHit) pinLevel <= 1'b0;
                `MODE_TOG_SET: begin
                    if (periodHit) pinLevel <= 1'b1;
                    else if (chanHit) pinLevel <= !pinLevel;
                end
                default: begin
                    if (periodHit) pinLevel <= 1'b1;
                    else if (chanHit) pinLevel <= 1'b0;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ### timer_channel_control.sv
// One capture/compare channel with its AXI4-Lite register slave
`include "chan_cfg.svh"
`default_nettype none
module timer_channel_control
    import chan_pkg::*;
#(
    parameter int          CNT_W          = 16,   // Timer count width
    parameter int          ADDR_W         = 8,    // Bus address width
    parameter logic        PERIOD_CHANNEL = 1'b0  // This is the period channel
) (
    input  wire logic              clock,      // Timer clock, 100 MHz
    input  wire logic              arst_n,     // Async reset, active low
    input  wire logic              ce,         // Freezes all state when low
    input  wire logic              awvalid,    // Write address valid
    output var  logic              awready,    // Write address ready
    input  wire logic [ADDR_W-1:0] awaddr,     // Write byte address
    input  wire logic              wvalid,     // Write data valid
    output var  logic              wready,     // Write data ready
    input  wire logic [31:0]       wdata,      // Write data
    input  wire logic [3:0]        wstrb,      // Write byte strobes
    output var  logic              bvalid,     // Write response valid
    input  wire logic              bready,     // Write response ready
    output var  logic [1:0]        bresp,      // Write response code
    input  wire logic              arvalid,    // Read address valid
    output var  logic              arready,    // Read address ready
    input  wire logic [ADDR_W-1:0] araddr,     // Read byte address
    output var  logic              rvalid,     // Read data valid
    input  wire logic              rready,     // Read data ready
    output var  logic [31:0]       rdata,      // Read data
    output var  logic [1:0]        rresp,      // Read response code
    input  wire logic              inputA,     // External source A pin
    input  wire logic              inputB,     // External source B pin
    input  wire logic [CNT_W-1:0]  timerCount, // Timer count
    input  wire logic              countTick,  // Count changed this cycle
    input  wire logic              periodMatch,// Period match pulse
    output var  logic              pinOut,     // Channel output
    output var  logic              channelIrq, // Channel interrupt request
    output var  logic              irq         // Event interrupt, level
);
    ctrl_t             ctrl;
    ctrl_t             ctrlRead;
    ctrl_t             ctrlMerged;
    logic [CNT_W-1:0]  value;
    event_t            status;
    event_t            enable;
    event_t            events;
    wr_state_t         wrState;
    rd_state_t         rdState;
    logic              awHeld;
    logic              wHeld;
    logic [ADDR_W-1:0] awAddrQ;
    logic [31:0]       wDataQ;
    logic [3:0]        wStrbQ;
    logic              levelA;
    logic              levelB;
    logic              selLevel;
    logic              prevSel;
    logic              trigger;
    logic              trigDelayed;
    logic              captureNow;
    logic              chanHit;
    logic              periodHit;
    logic              commit;
    logic              ctrlWrite;
    logic              valueWrite;
    logic              clearWrite;
    logic              enableWrite;
    logic              mapped;

    // Pin synchronisers for the two external sources
    pin_sync syncA (
        .clock  (clock),
        .arst_n (arst_n),
        .ce     (ce),
        .pin    (inputA),
        .level  (levelA)
    );
    pin_sync syncB (
        .clock  (clock),
        .arst_n (arst_n),
        .ce     (ce),
        .pin    (inputB),
        .level  (levelB)
    );

    // Input multiplexer
    always_comb begin
        case (ctrl.inputSourceSelect)
            `SRC_A:   selLevel = levelA;
            `SRC_B:   selLevel = levelB;
            `SRC_GND: selLevel = 1'b0;
            default:  selLevel = 1'b1;
        endcase
    end

    // Edge trigger; changing the source can itself look like an edge
    always_comb begin
        case (ctrl.edgeSelect)
            `EDGE_RISE: trigger = selLevel && !prevSel;
            `EDGE_FALL: trigger = !selLevel && prevSel;
            `EDGE_BOTH: trigger = selLevel != prevSel;
            default:    trigger = 1'b0;
        endcase
    end

    // Sync mode spends one extra clock so capture lands on a clean edge
    assign captureNow = trigDelayed
                      || (trigger && !ctrl.syncCapture
                          && ctrl.latchOnEdgeSelect);
    assign chanHit    = !ctrl.latchOnEdgeSelect && countTick
                      && (timerCount == value);
    // Both matches coincide on the period channel
    assign periodHit  = PERIOD_CHANNEL ? chanHit : periodMatch;
    assign events     = '{overflow: captureNow && ctrl.channelIrqFlag,
                          compare:  chanHit,
                          capture:  captureNow};

    // Edge history and sync delay stage
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            prevSel     <= 1'b0;
            trigDelayed <= 1'b0;
        end else if (ce) begin
            prevSel     <= selLevel;
            trigDelayed <= trigger && ctrl.syncCapture
                        && ctrl.latchOnEdgeSelect;
        end
    end

    pin_action_unit outUnit (
        .clock     (clock),
        .arst_n    (arst_n),
        .ce        (ce),
        .mode      (ctrl.pinActionSelect),
        .outBit    (ctrl.outBit),
        .chanHit   (chanHit),
        .periodHit (periodHit),
        .pinLevel  (pinOut)
    );

    // Register decode of the committed write
    assign commit      = ce && wrState == WR_IDLE && awHeld && wHeld;
    assign ctrlWrite   = commit && awAddrQ == `OFS_CTRL;
    assign valueWrite  = commit && awAddrQ == `OFS_VALUE;
    assign clearWrite  = commit && awAddrQ == `OFS_CLEAR;
    assign enableWrite = commit && awAddrQ == `OFS_ENABLE;
    assign mapped      = awAddrQ == `OFS_CTRL || awAddrQ == `OFS_VALUE
                      || awAddrQ == `OFS_STATUS || awAddrQ == `OFS_CLEAR
                      || awAddrQ == `OFS_ENABLE;
    assign ctrlMerged  = {wStrbQ[1] ? wDataQ[15:8] : ctrl[15:8],
                          wStrbQ[0] ? wDataQ[7:0]  : ctrl[7:0]};

    // Control word; hardware sets after the write so set beats clear
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ctrl <= `CTRL_RESET;
        end else if (ce) begin
            if (ctrlWrite) begin
                ctrl.edgeSelect        <= ctrlMerged.edgeSelect;
                ctrl.inputSourceSelect <= ctrlMerged.inputSourceSelect;
                ctrl.syncCapture       <= ctrlMerged.syncCapture;
                ctrl.latchOnEdgeSelect <= ctrlMerged.latchOnEdgeSelect;
                ctrl.pinActionSelect   <= ctrlMerged.pinActionSelect;
                ctrl.channelIrqEnable  <= ctrlMerged.channelIrqEnable;
                ctrl.outBit            <= ctrlMerged.outBit;
                ctrl.captureOverflow   <= ctrlMerged.captureOverflow;
                ctrl.channelIrqFlag    <= ctrlMerged.channelIrqFlag;
            end
            if (chanHit) begin
                ctrl.latchedSyncInput <= selLevel;
            end
            if (events.overflow) begin
                ctrl.captureOverflow <= 1'b1;
            end
            if (captureNow || chanHit) begin
                ctrl.channelIrqFlag <= 1'b1;
            end
        end
    end

    // Channel value: capture wins over a software write
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            value <= `VALUE_RESET;
        end else if (ce) begin
            if (captureNow) begin
                value <= timerCount;
            end else if (valueWrite) begin
                value <= {wStrbQ[1] ? wDataQ[15:8] : value[15:8],
                          wStrbQ[0] ? wDataQ[7:0]  : value[7:0]};
            end
        end
    end

    // Sticky status, enable mask and registered interrupt lines
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            status     <= '0;
            enable     <= '0;
            irq        <= 1'b0;
            channelIrq <= 1'b0;
        end else if (ce) begin
            status <= (status & ~(clearWrite ? event_t'(wDataQ[2:0])
                                             : event_t'('0))) | events;
            if (enableWrite) begin
                enable <= event_t'(wDataQ[2:0]);
            end
            irq        <= |(status & enable);
            channelIrq <= ctrl.channelIrqFlag
                       && ctrl.channelIrqEnable;
        end
    end

    // Read view: live input level and a hard zero in the unused bit
    always_comb begin
        ctrlRead                    = ctrl;
        ctrlRead.selectedInputLevel = selLevel;
        ctrlRead.unusedBit          = 1'b0;
    end

    // Write channel: address and data taken in either order
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wrState <= WR_IDLE;
            awready <= 1'b0;
            wready  <= 1'b0;
            awHeld  <= 1'b0;
            wHeld   <= 1'b0;
            awAddrQ <= '0;
            wDataQ  <= '0;
            wStrbQ  <= '0;
            bvalid  <= 1'b0;
            bresp   <= `RESP_OKAY;
        end else if (ce) begin
            case (wrState)
                WR_IDLE: begin
                    if (awvalid && awready) begin
                        awAddrQ <= awaddr;
                        awHeld  <= 1'b1;
                        awready <= 1'b0;
                    end else if (!awHeld) begin
                        awready <= 1'b1;
                    end
                    if (wvalid && wready) begin
                        wDataQ <= wdata;
                        wStrbQ <= wstrb;
                        wHeld  <= 1'b1;
                        wready <= 1'b0;
                    end else if (!wHeld) begin
                        wready <= 1'b1;
                    end
                    if (commit) begin
                        bvalid  <= 1'b1;
                        bresp   <= mapped ? `RESP_OKAY : `RESP_SLVERR;
                        wrState <= WR_RESP;
                    end
                end
                WR_RESP: begin
                    if (bready) begin
                        bvalid  <= 1'b0;
                        awHeld  <= 1'b0;
                        wHeld   <= 1'b0;
                        wrState <= WR_IDLE;
                    end
                end
                default: wrState <= WR_IDLE;
            endcase
        end
    end

    // Read channel: data one clock after the address is taken
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rdState <= RD_IDLE;
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= `RESP_OKAY;
        end else if (ce) begin
            case (rdState)
                RD_IDLE: begin
                    if (arvalid && arready) begin
                        arready <= 1'b0;
                        rvalid  <= 1'b1;
                        rresp   <= `RESP_OKAY;
                        rdState <= RD_RESP;
                        case (araddr)
                            `OFS_CTRL:   rdata <= {16'h0000, ctrlRead};
                            `OFS_VALUE:  rdata <= {16'h0000, value};
                            `OFS_STATUS: rdata <= {29'h0000000, status};
                            `OFS_ENABLE: rdata <= {29'h0000000, enable};
                            default: begin
                                rdata <= '0;
                                rresp <= `RESP_SLVERR;
                            end
                        endcase
                    end else begin
                        arready <= 1'b1;
                    end
                end
                RD_RESP: begin
                    if (rready) begin
                        rvalid  <= 1'b0;
                        rdState <= RD_IDLE;
                    end
                end
                default: rdState <= RD_IDLE;
            endcase
        end
    end

    // Checks on the channel behaviour
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    sequence syncTrig;
        ce && trigger && ctrl.syncCapture && ctrl.latchOnEdgeSelect;
    endsequence
    sequence ctrlReadTaken;
        ce && arvalid && arready && rdState == RD_IDLE
            && araddr == `OFS_CTRL;
    endsequence

    a_source_route: assert property (
        ctrl.inputSourceSelect == `SRC_VCC |-> selLevel
    ) else $error("constant high source not routed");
    a_sync_delay: assert property (
        syncTrig ##1 ce |-> captureNow
    ) else $error("synchronised capture not one clock late");
    a_async_now: assert property (
        ce && trigger && !ctrl.syncCapture && ctrl.latchOnEdgeSelect
            |=> ctrl.channelIrqFlag && value == $past(timerCount)
    ) else $error("asynchronous capture delayed");
    a_latch_match: assert property (
        ce && chanHit |=> ctrl.latchedSyncInput == $past(selLevel)
    ) else $error("latched input not taken at match");
    a_unused_zero: assert property (
        ctrlReadTaken |=> rdata[9] == 1'b0
    ) else $error("unused control bit read nonzero");
    a_capture_count: assert property (
        ce && captureNow |=> value == $past(timerCount)
    ) else $error("count not captured");
    a_irq_gate: assert property (
        ce && ctrl.channelIrqFlag && !ctrl.channelIrqEnable |=> !channelIrq
    ) else $error("channel request not gated by enable");
    a_level_read: assert property (
        ctrlReadTaken |=> rdata[3] == $past(selLevel)
    ) else $error("selected input level misread");
    a_direct_out: assert property (
        ce && ctrl.pinActionSelect == `MODE_DIRECT
            |=> pinOut == $past(ctrl.outBit)
    ) else $error("output not following direct bit");
    a_ovf_sticky: assert property (
        ctrl.captureOverflow && !ctrlWrite |=> ctrl.captureOverflow
    ) else $error("overflow cleared by hardware");
    a_ovf_set: assert property (
        ce && captureNow && ctrl.channelIrqFlag |=> ctrl.captureOverflow
    ) else $error("overflow not flagged");
    a_edge_none: assert property (
        ctrl.edgeSelect == `EDGE_NONE |-> !trigger
    ) else $error("trigger with no edge selected");
    a_flag_set: assert property (
        ce && (captureNow || chanHit) |=> ctrl.channelIrqFlag
    ) else $error("channel flag not set");
endmodule
`default_nettype wire

// ### chan_pins_model.sv
// Far-side model: external capture source pins of the channel
`default_nettype none
module chan_pins_model (
    input  wire logic clock,  // Timer clock
    input  wire logic wantA,  // Level asked for on source A
    input  wire logic wantB,  // Level asked for on source B
    output var  logic inputA, // Source A pin
    output var  logic inputB  // Source B pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pins move off the edge: a real source is unrelated to the clock
    always @(posedge clock) begin
        inputA <= #3 wantA;
        inputB <= #3 wantB;
    end
endmodule
`default_nettype wire

// ### timer_channel_control_tb.sv
// Self-checking bench for the capture/compare channel
`include "chan_cfg.svh"
`default_nettype none
module timer_channel_control_tb import chan_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, arst_n = 0, ce = 1, awvalid = 0, wvalid = 0;
    logic bready = 0, arvalid = 0, rready = 0, countTick = 0;
    logic periodMatch = 0, wantA = 0, wantB = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0;
    logic [3:0] wstrb = 4'hF;
    logic [15:0] timerCount = 0;
    logic awready, wready, bvalid, arready, rvalid, inputA, inputB;
    logic pinOut, channelIrq, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int badCount = 0, nChecks = 0;
    always #5 clock = ~clock;
    chan_pins_model chan_pins_model_inst (.clock(clock), .wantA(wantA),
        .wantB(wantB), .inputA(inputA), .inputB(inputB));
    timer_channel_control timer_channel_control_inst (.clock(clock),
        .arst_n(arst_n), .ce(ce), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .inputA(inputA), .inputB(inputB), .timerCount(timerCount),
        .countTick(countTick), .periodMatch(periodMatch),
        .pinOut(pinOut), .channelIrq(channelIrq), .irq(irq));
    // Compare one value and count it
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            badCount++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    // Write: address and data offered together, each released when taken
    task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        fork
            begin
                do @(posedge clock); while (awready !== 1'b1);
                awvalid <= 1'b0;
            end
            begin
                do @(posedge clock); while (wready !== 1'b1);
                wvalid <= 1'b0;
            end
        join
        while (bvalid !== 1'b1) @(posedge clock);
        bready <= 1'b0;
        check("bresp", bresp, er);
    endtask
    // Read and compare the masked word and the response code
    task automatic rd(logic [7:0] a, logic [31:0] m, e, logic [1:0] er);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clock); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clock); while (rvalid !== 1'b1);
        rready <= 1'b0;
        check("rdata", rdata & m, e);
        check("rresp", rresp, er);
    endtask
    // One counting step of the timer, with or without a period match
    task automatic hit(logic [15:0] c, logic p);
        @(posedge clock);
        timerCount <= c;
        countTick <= 1'b1;
        periodMatch <= p;
        @(posedge clock);
        countTick <= 1'b0;
        periodMatch <= 1'b0;
        repeat (3) @(posedge clock);
    endtask
    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", nChecks, badCount);
        if (badCount == 0 && nChecks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Watchdog: the whole sequence needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge clock);
        badCount++;
        giveVerdict();
    end
    initial begin
        repeat (16) @(posedge clock);
        arst_n <= 1'b1;
        repeat (2) @(posedge clock);
        rd(`OFS_CTRL, 32'hFFFF_FFFF, 0, `RESP_OKAY);
        rd(`OFS_STATUS, 32'hFFFF_FFFF, 0, `RESP_OKAY);
        // Read-only bits keep their own value; flag bits masked
        wr(`OFS_CTRL, 32'hFFFF, `RESP_OKAY);
        repeat (8) @(posedge clock);
        rd(`OFS_CTRL, 32'hFFFC, 32'hF9FC, `RESP_OKAY);
        wantB <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            wr(`OFS_CTRL, 32'(s) << 12, `RESP_OKAY);
            repeat (8) @(posedge clock);
            rd(`OFS_CTRL, 32'h8, 32'(s % 2) << 3, `RESP_OKAY);
        end
        for (int v = 0; v < 2; v++) begin
            wr(`OFS_CTRL, 32'(v) << 2, `RESP_OKAY);
            repeat (2) @(posedge clock);
            check("pinOut", pinOut, v);
        end
        // Rising capture, ignored falling edge, then an overflow
        wr(`OFS_ENABLE, 32'h5, `RESP_OKAY);
        wr(`OFS_CTRL, 32'h4110, `RESP_OKAY);
        timerCount <= 16'h1234;
        wantA <= 1'b1;
        repeat (10) @(posedge clock);
        rd(`OFS_VALUE, 32'hFFFF, 32'h1234, `RESP_OKAY);
        rd(`OFS_CTRL, 32'h3, 32'h1, `RESP_OKAY);
        check("channelIrq", channelIrq, 1);
        timerCount <= 16'h2222;
        wantA <= 1'b0;
        repeat (10) @(posedge clock);
        rd(`OFS_VALUE, 32'hFFFF, 32'h1234, `RESP_OKAY);
        timerCount <= 16'h5678;
        wantA <= 1'b1;
        repeat (10) @(posedge clock);
        rd(`OFS_CTRL, 32'h3, 32'h3, `RESP_OKAY);
        rd(`OFS_STATUS, 32'h7, 32'h5, `RESP_OKAY);
        check("irq", irq, 1);
        wr(`OFS_STATUS, 32'h0, `RESP_OKAY);
        wr(`OFS_CLEAR, 32'h7, `RESP_OKAY);
        wr(`OFS_CTRL, 32'h4110, `RESP_OKAY);
        rd(`OFS_STATUS, 32'h7, 32'h0, `RESP_OKAY);
        rd(`OFS_CTRL, 32'h3, 32'h0, `RESP_OKAY);
        check("channelIrq", channelIrq, 0);
        check("irq", irq, 0);
        // Compare: set on match, then reset on match
        wr(`OFS_VALUE, 32'h50, `RESP_OKAY);
        wr(`OFS_CTRL, 32'h30, `RESP_OKAY);
        hit(16'h50, 1'b0);
        check("pinOut", pinOut, 1);
        rd(`OFS_CTRL, 32'h401, 32'h401, `RESP_OKAY);
        wr(`OFS_CTRL, 32'hA0, `RESP_OKAY);
        hit(16'h50, 1'b0);
        check("pinOut", pinOut, 0);
        // Reset/set: period match sets, channel match resets
        wr(`OFS_CTRL, 32'hE0, `RESP_OKAY);
        hit(16'h10, 1'b1);
        check("pinOut", pinOut, 1);
        hit(16'h50, 1'b0);
        check("pinOut", pinOut, 0);
        wr(`OFS_CTRL, 32'h80, `RESP_OKAY);
        hit(16'h50, 1'b0);
        check("pinOut", pinOut, 1);
        wr(8'h14, 32'h1, `RESP_SLVERR);
        rd(8'h14, 32'hFFFF_FFFF, 0, `RESP_SLVERR);
        giveVerdict();
    end
endmodule
`default_nettype wire
